/* File: src/fcp_fclk_div.sv */
`timescale 1ns/1ps
module fcp_fclk_div
  import fcp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic pre8,
  input wire logic [5:0] div,
  output logic tick
);
  typedef struct packed {
    logic [8:0] cnt;
    logic tick;
  } fcp_div_st_t;
  fcp_div_st_t s_q;
  fcp_div_st_t s_d;
  logic [8:0] lim;

  // ====================================================
  // One tick per flash clock period
  always_comb
  begin
    lim = pre8 ? {div + 6'h01, 3'h0} - 9'h001 : {3'h0, div};
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!en)
      s_d.cnt = 9'h000;
    else if (s_q.cnt >= lim)
    begin
      s_d.cnt = 9'h000;
      s_d.tick = 1'b1;
    end
    else
      s_d.cnt = s_q.cnt + 9'h001;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick = s_q.tick;
endmodule

/* File: src/fcp_flash_ctrl.sv */
`timescale 1ns/1ps
module fcp_flash_ctrl
  import fcp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_dbg,
  input wire logic bus_unsec,
  output logic [7:0] bus_rdata,
  input wire logic [7:0] mem_rdata,
  output logic mem_wr,
  output logic mem_rd,
  input wire logic [7:0] nv_prot,
  input wire logic [7:0] nv_opt,
  input wire logic [63:0] nv_backkey,
  input wire logic stop_req,
  input wire logic vec_fetch,
  output logic [15:0] vec_addr,
  input wire logic arr_blank,
  output logic pump_en,
  output logic arr_prog,
  output logic arr_erase_page,
  output logic arr_erase_mass,
  output logic arr_blank_chk,
  output logic [15:0] arr_addr,
  output logic [7:0] arr_data,
  output logic secure
);
  typedef struct packed {
    logic loaded;
    logic [7:0] prot;
    logic [7:0] opt;
    logic divld;
    logic [6:0] div;
    logic key_compare_access_bit;
    logic accerr;
    logic pviol;
    logic blank;
    fcp_seq_t seq;
    logic [15:0] lat_addr;
    logic [7:0] lat_data;
    logic [7:0] lat_cmd;
    logic buf_full;
    logic [7:0] buf_cmd;
    logic [15:0] buf_addr;
    logic [7:0] buf_data;
    fcp_op_t ex_op;
    logic ex_burst;
    logic [15:0] ex_addr;
    logic [7:0] ex_data;
    logic [14:0] ex_cnt;
    logic pump;
    logic [3:0] key_idx;
    logic key_ok;
    logic key_last;
    logic [7:0] rdata;
    logic [15:0] vaddr;
  } fcp_st_t;

  fcp_st_t s_q, s_d;
  logic rst_q1, rst_q2, tick, cbef, secured, blocked, in_ram, in_flash;
  logic key_hit, is_reg, arr_w, any_prot, partial, cont, launch_bad;
  logic [16:0] prot_lo, red_base;
  logic [15:0] next_addr;
  logic [7:0] key_byte;

  // ====================================================
  // Reset release
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  fcp_fclk_div u_div (
    .core_clk(core_clk),
    .rst_n(rst_q2),
    .en(s_q.divld),
    .pre8(s_q.div[6]),
    .div(s_q.div[5:0]),
    .tick(tick)
  );

  function automatic fcp_op_t op_of(input logic [7:0] c);
    unique case (c)
      FCP_CMD_BYTE: op_of = FCP_OP_PROG;
      FCP_CMD_BURST: op_of = FCP_OP_PROG;
      FCP_CMD_PAGE: op_of = FCP_OP_PAGE;
      FCP_CMD_MASS: op_of = FCP_OP_MASS;
      default: op_of = FCP_OP_BLANK;
    endcase
  endfunction
  function automatic logic [14:0] time_of(input logic [7:0] c);
    unique case (c)
      FCP_CMD_BYTE: time_of = FCP_T_PROG;
      FCP_CMD_BURST: time_of = FCP_T_PROG;
      FCP_CMD_PAGE: time_of = FCP_T_PAGE;
      FCP_CMD_MASS: time_of = FCP_T_MASS;
      default: time_of = FCP_T_BLANK;
    endcase
  endfunction

  // ====================================================
  // Decode
  // Block size grows by powers of two from the top end
  assign prot_lo = FCP_TOP - (FCP_BLK_UNIT << s_q.prot[6:4]);
  assign red_base = prot_lo - FCP_VEC_TBL;
  assign any_prot = s_q.prot[FCP_PR_ALL] || !s_q.prot[FCP_PR_BLKDIS];
  assign partial = !s_q.prot[FCP_PR_ALL] && !s_q.prot[FCP_PR_BLKDIS];
  assign cbef = !s_q.buf_full;
  assign secured = s_q.opt[1:0] != FCP_SEC_OPEN; // RL19
  assign blocked = secured && (bus_dbg || bus_unsec); // RL18
  assign in_ram = bus_addr >= FCP_RAM_LO && bus_addr <= FCP_RAM_HI;
  assign in_flash = bus_addr >= FCP_FLASH_LO;
  assign key_hit = s_q.key_compare_access_bit && bus_addr[15:3] == FCP_KEY_BASE[15:3];
  assign is_reg = bus_addr >= FCP_DIV_ADDR && bus_addr <= FCP_CMD_ADDR;
  assign arr_w = bus_wr && in_flash && !key_hit;
  assign next_addr = s_q.ex_addr + 16'h0001;
  assign key_byte = nv_backkey[8'(63 - 8 * s_q.key_idx[2:0]) -: 8];
  // Burst continues only with a queued, sequential, same-row byte
  assign cont = s_q.ex_burst && s_q.buf_full && s_q.buf_cmd == FCP_CMD_BURST
    && s_q.buf_addr == next_addr && s_q.buf_addr[FCP_ROW_W-1:0] != 6'h00; // RL1 RL2 RL4
  assign launch_bad = ((s_q.lat_cmd == FCP_CMD_BYTE || s_q.lat_cmd == FCP_CMD_BURST
    || s_q.lat_cmd == FCP_CMD_PAGE) && (s_q.prot[FCP_PR_ALL]
    || (!s_q.prot[FCP_PR_BLKDIS] && {1'b0, s_q.lat_addr} >= prot_lo)))
    || (s_q.lat_cmd == FCP_CMD_MASS && any_prot); // RL15

  // ====================================================
  // Next state
  always_comb
  begin
    s_d = s_q;
    s_d.key_last = 1'b0;
    // Option and protection copies taken once after reset release
    if (!s_q.loaded)
    begin
      s_d.loaded = 1'b1;
      s_d.prot = nv_prot; // RL16
      s_d.opt = nv_opt; // RL19
    end

    // Bus writes
    if (bus_wr && key_hit)
    begin
      // Back-to-back or out-of-order key writes spoil the match
      s_d.key_last = 1'b1;
      if (s_q.key_last || s_q.key_idx >= FCP_KEY_LEN
          || bus_addr[2:0] != s_q.key_idx[2:0] || bus_wdata != key_byte)
        s_d.key_ok = 1'b0; // RL20
      if (s_q.key_idx < FCP_KEY_LEN)
        s_d.key_idx = s_q.key_idx + 4'h1;
    end
    else if (arr_w)
    begin
      if (!s_q.divld)
        s_d.accerr = 1'b1; // RL7
      else if (!cbef)
        s_d.accerr = 1'b1; // RL8
      else if (s_q.seq != FCP_SEQ_IDLE)
        s_d.accerr = 1'b1; // RL9
      else if (!s_q.accerr)
      begin
        s_d.seq = FCP_SEQ_ADDR; // RL6
        s_d.lat_addr = bus_addr;
        s_d.lat_data = bus_wdata;
      end
    end
    else if (bus_wr && is_reg)
    begin
      if (s_q.seq == FCP_SEQ_ADDR && bus_addr != FCP_CMD_ADDR
          && bus_addr != FCP_STAT_ADDR)
        s_d.accerr = 1'b1; // RL10
      if (s_q.seq == FCP_SEQ_CMD && bus_addr != FCP_STAT_ADDR)
        s_d.accerr = 1'b1; // RL10
      unique case (bus_addr)
        FCP_DIV_ADDR:
        begin
          // Write-once; refused while an error is pending
          if (!s_q.divld && !s_q.accerr)
          begin
            s_d.divld = 1'b1;
            s_d.div = bus_wdata[6:0];
          end
        end
        FCP_CFG_ADDR:
        begin
          if (bus_wdata[FCP_CFG_KEY_COMPARE_ACCESS_BIT] && s_q.opt[FCP_OPT_BACKDOOR_ALLOW_BIT] && !s_q.key_compare_access_bit)
          begin
            s_d.key_compare_access_bit = 1'b1;
            s_d.key_idx = 4'h0;
            s_d.key_ok = 1'b1;
          end
          else if (!bus_wdata[FCP_CFG_KEY_COMPARE_ACCESS_BIT] && s_q.key_compare_access_bit)
          begin
            s_d.key_compare_access_bit = 1'b0;
            if (s_q.key_ok && s_q.key_idx == FCP_KEY_LEN)
              s_d.opt[1:0] = FCP_SEC_OPEN; // RL20
          end
        end
        FCP_PROT_ADDR:
        begin
          if (bus_dbg)
            s_d.prot = bus_wdata; // RL16
        end
        FCP_STAT_ADDR:
        begin
          if (bus_wdata[FCP_ST_ACCERR])
            s_d.accerr = 1'b0; // RL6
          if (bus_wdata[FCP_ST_PVIOL])
            s_d.pviol = 1'b0;
          if (s_q.seq != FCP_SEQ_IDLE && !bus_wdata[FCP_ST_CBEF])
            s_d.accerr = 1'b1; // RL14
          else if (s_q.seq == FCP_SEQ_ADDR)
            s_d.accerr = 1'b1; // RL10
          else if (s_q.seq == FCP_SEQ_CMD && !s_q.accerr)
          begin
            s_d.seq = FCP_SEQ_IDLE;
            if (launch_bad)
              s_d.pviol = 1'b1; // RL15
            else
            begin
              s_d.buf_full = 1'b1; // RL24
              s_d.buf_cmd = s_q.lat_cmd;
              s_d.buf_addr = s_q.lat_addr;
              s_d.buf_data = s_q.lat_data;
            end
          end
        end
        FCP_CMD_ADDR:
        begin
          if (s_q.seq == FCP_SEQ_CMD)
            s_d.accerr = 1'b1; // RL9
          else if (s_q.seq == FCP_SEQ_ADDR)
          begin
            if (bus_wdata != FCP_CMD_BLANK && bus_wdata != FCP_CMD_BYTE
                && bus_wdata != FCP_CMD_BURST && bus_wdata != FCP_CMD_PAGE
                && bus_wdata != FCP_CMD_MASS)
              s_d.accerr = 1'b1; // RL11
            else if (secured && bus_dbg && bus_wdata != FCP_CMD_BLANK
                     && bus_wdata != FCP_CMD_MASS)
              s_d.accerr = 1'b1; // RL13
            else
            begin
              s_d.seq = FCP_SEQ_CMD; // RL23
              s_d.lat_cmd = bus_wdata;
            end
          end
        end
        default: ;
      endcase
    end
    // Command engine
    if (s_q.ex_op != FCP_OP_NONE)
    begin
      if (stop_req && s_q.ex_op != FCP_OP_BLANK)
      begin
        s_d.ex_op = FCP_OP_NONE; // RL12
        s_d.pump = 1'b0;
        s_d.accerr = 1'b1; // RL12
      end
      else if (tick && s_q.ex_cnt == 15'h0001)
      begin
        if (s_q.ex_op == FCP_OP_BLANK && arr_blank)
        begin
          s_d.blank = 1'b1;
          s_d.opt[1:0] = FCP_SEC_OPEN; // RL22
        end
        if (cont)
        begin
          s_d.buf_full = 1'b0;
          s_d.ex_addr = s_q.buf_addr;
          s_d.ex_data = s_q.buf_data;
          s_d.ex_cnt = FCP_T_BURST; // RL3
        end
        else
        begin
          // Pump off; a waiting program or erase command restarts it next cycle, a waiting blank check leaves it off
          s_d.ex_op = FCP_OP_NONE; // RL5
          s_d.pump = 1'b0; // RL4
        end
      end
      else if (tick)
        s_d.ex_cnt = s_q.ex_cnt - 15'h0001;
    end
    else if (s_q.buf_full)
    begin
      s_d.buf_full = 1'b0;
      s_d.ex_op = op_of(s_q.buf_cmd);
      s_d.ex_burst = s_q.buf_cmd == FCP_CMD_BURST;
      s_d.ex_addr = s_q.buf_addr;
      s_d.ex_data = s_q.buf_data;
      s_d.ex_cnt = time_of(s_q.buf_cmd); // RL3
      s_d.pump = s_q.buf_cmd != FCP_CMD_BLANK;
    end

    // Any new error drops a half-built sequence
    if (s_d.accerr && !s_q.accerr)
      s_d.seq = FCP_SEQ_IDLE; // RL6

    // Read data, registered
    s_d.rdata = 8'h00;
    if (bus_rd && is_reg)
    begin
      unique case (bus_addr)
        FCP_DIV_ADDR: s_d.rdata = {s_q.divld, s_q.div};
        FCP_OPT_ADDR: s_d.rdata = s_q.opt & FCP_OPT_RDMASK;
        FCP_CFG_ADDR: s_d.rdata = {2'h0, s_q.key_compare_access_bit, 5'h00};
        FCP_PROT_ADDR: s_d.rdata = s_q.prot;
        FCP_STAT_ADDR: s_d.rdata = {cbef, cbef && s_q.ex_op == FCP_OP_NONE,
                                    s_q.pviol, s_q.accerr, 1'b0, s_q.blank, 2'h0};
        default: s_d.rdata = 8'h00;
      endcase
    end
    else if (mem_rd)
      s_d.rdata = mem_rdata;

    // Vector fetch with optional redirection
    if (vec_fetch)
    begin
      if (!s_q.opt[FCP_OPT_NORED] && partial && bus_addr >= FCP_VEC_LO
          && bus_addr <= FCP_VEC_HI)
        s_d.vaddr = {red_base[15:6], bus_addr[5:0]}; // RL17 RL25
      else
        s_d.vaddr = bus_addr;
    end
  end

  always_ff @(posedge core_clk or negedge rst_q2)
  begin
    if (!rst_q2)
    begin
      s_q <= '0;
      s_q.seq <= FCP_SEQ_IDLE;
      s_q.ex_op <= FCP_OP_NONE;
    end
    else
      s_q <= s_d;
  end

  // ====================================================
  // Outputs
  // Key compare hides the whole array so the key cannot be read back
  assign mem_rd = bus_rd && !is_reg && (in_ram || in_flash) && !blocked
    && !(in_flash && s_q.key_compare_access_bit); // RL18 RL21
  assign mem_wr = bus_wr && in_ram && !blocked; // RL18
  assign bus_rdata = s_q.rdata;
  assign vec_addr = s_q.vaddr;
  assign pump_en = s_q.pump;
  assign arr_prog = s_q.ex_op == FCP_OP_PROG;
  assign arr_erase_page = s_q.ex_op == FCP_OP_PAGE;
  assign arr_erase_mass = s_q.ex_op == FCP_OP_MASS;
  assign arr_blank_chk = s_q.ex_op == FCP_OP_BLANK;
  assign arr_addr = s_q.ex_addr;
  assign arr_data = s_q.ex_data;
  assign secure = secured;
endmodule

/* File: src/fcp_pkg.sv */
// Overview of operation
// RL1: Pump stays on only if next burst queued
// RL2: Rows are 64 bytes, low six address bits
// RL3: First burst byte standard time, then burst time
// RL4: New row cycles pump, standard time
// RL5: Nothing queued at completion: pump off
// RL6: Violations set access error; clear by writing 1
// RL7: Array write before divider write is error
// RL8: Array write with buffer not empty is error
// RL9: Second array or command write is error
// RL10: Only command, then launch, may follow
// RL11: Only five command codes are legal
// RL12: Stop during program or erase aborts, errors
// RL13: Secured debug may only blank check, mass erase
// RL14: Writing 0 to buffer-empty flag aborts, errors
// RL15: Protected range blocks program, erase, mass erase
// RL16: Protection loads at reset; debug-only writes
// RL17: Partial protection redirects interrupt vectors only
// RL18: Secured: blocked sources read zero, writes dropped
// RL19: Security bits open only for pattern 1:0
// RL20: Eight ordered key bytes unlock until reset
// RL21: No flash reads while key compare active
// RL22: Passing blank check disengages security
// RL23: Codes: blank, byte, burst, page, mass
// RL24: Software launches by writing 1 to flag
// RL25: Redirected vectors sit just below protection
package fcp_pkg;
  // ====================================================
  // Register and memory map
  localparam logic [15:0] FCP_DIV_ADDR = 16'h1820;
  localparam logic [15:0] FCP_OPT_ADDR = 16'h1821;
  localparam logic [15:0] FCP_CFG_ADDR = 16'h1823;
  localparam logic [15:0] FCP_PROT_ADDR = 16'h1824;
  localparam logic [15:0] FCP_STAT_ADDR = 16'h1825;
  localparam logic [15:0] FCP_CMD_ADDR = 16'h1826;
  localparam logic [15:0] FCP_NONVOLATILE_PROTECTION_BYTE_ADDR = 16'hFFBD;
  localparam logic [15:0] FCP_NONVOLATILE_OPTION_BYTE_ADDR = 16'hFFBF;
  localparam logic [15:0] FCP_KEY_BASE = 16'hFFB0;
  localparam logic [15:0] FCP_RAM_LO = 16'h0070;
  localparam logic [15:0] FCP_RAM_HI = 16'h086F;
  localparam logic [15:0] FCP_FLASH_LO = 16'h1870;
  localparam logic [15:0] FCP_VEC_LO = 16'hFFC0;
  localparam logic [15:0] FCP_VEC_HI = 16'hFFFD;
  localparam logic [16:0] FCP_VEC_TBL = 17'h00040;
  localparam logic [16:0] FCP_TOP = 17'h10000;
  localparam logic [16:0] FCP_BLK_UNIT = 17'h00200;
  localparam int FCP_ROW_W = 6;
  // ====================================================
  // Field positions
  localparam int FCP_ST_CBEF = 7;
  localparam int FCP_ST_CCF = 6;
  localparam int FCP_ST_PVIOL = 5;
  localparam int FCP_ST_ACCERR = 4;
  localparam int FCP_ST_BLANK = 2;
  localparam int FCP_CFG_KEY_COMPARE_ACCESS_BIT = 5;
  localparam int FCP_OPT_BACKDOOR_ALLOW_BIT = 7;
  localparam int FCP_OPT_NORED = 6;
  localparam int FCP_PR_BLKDIS = 7;
  localparam int FCP_PR_ALL = 0;
  localparam logic [7:0] FCP_OPT_RDMASK = 8'hC3;
  localparam logic [1:0] FCP_SEC_OPEN = 2'h2;
  localparam logic [3:0] FCP_KEY_LEN = 4'h8;
  // ====================================================
  // Commands and durations in flash clock cycles
  localparam logic [7:0] FCP_CMD_BLANK = 8'h05;
  localparam logic [7:0] FCP_CMD_BYTE = 8'h20;
  localparam logic [7:0] FCP_CMD_BURST = 8'h25;
  localparam logic [7:0] FCP_CMD_PAGE = 8'h40;
  localparam logic [7:0] FCP_CMD_MASS = 8'h41;
  localparam logic [14:0] FCP_T_PROG = 15'h0009;
  localparam logic [14:0] FCP_T_BURST = 15'h0004;
  localparam logic [14:0] FCP_T_PAGE = 15'h0FA0;
  localparam logic [14:0] FCP_T_MASS = 15'h4E20;
  localparam logic [14:0] FCP_T_BLANK = 15'h0001;
  // ====================================================
  // Types
  typedef enum logic [2:0] {
    FCP_SEQ_IDLE = 3'h1,
    FCP_SEQ_ADDR = 3'h2,
    FCP_SEQ_CMD = 3'h4
  } fcp_seq_t;
  typedef enum logic [4:0] {
    FCP_OP_NONE = 5'h01,
    FCP_OP_PROG = 5'h02,
    FCP_OP_PAGE = 5'h04,
    FCP_OP_MASS = 5'h08,
    FCP_OP_BLANK = 5'h10
  } fcp_op_t;
endpackage

/* File: tb/fcp_array_model.sv */
`timescale 1ns/1ps
module fcp_array_model
  import fcp_pkg::*;
(
  input wire logic core_clk,
  input wire logic [15:0] bus_addr,
  input wire logic bus_rd,
  input wire logic arr_prog,
  input wire logic arr_erase_mass,
  output logic [7:0] mem_rdata,
  output logic arr_blank
);
  // ======
  // Array contents and erased state
  logic [7:0] churn_q = 8'h3C;
  logic erased_q = 1'b1;
  // Idle data churns so a stale byte never passes for a read
  assign mem_rdata = bus_rd ? (bus_addr[7:0] ^ 8'hA5) : churn_q;
  assign arr_blank = erased_q;
  always @(posedge core_clk)
  begin
    churn_q <= churn_q + 8'h35;
    if (arr_prog)
      erased_q <= 1'b0;
    else if (arr_erase_mass)
      erased_q <= 1'b1;
  end
endmodule

/* File: tb/fcp_flash_ctrl_test.sv */
`timescale 1ns/1ps
module fcp_flash_ctrl_test;
  import fcp_pkg::*;
  // ======
  // Signals
  logic core_clk, rstn, bus_wr, bus_rd, bus_dbg, bus_unsec, stop_req, vec_fetch, arr_blank;
  logic mem_wr, mem_rd, pump_en, arr_prog, arr_erase_page, arr_erase_mass, arr_blank_chk;
  logic secure, pump_prev;
  logic [15:0] bus_addr, vec_addr, arr_addr;
  logic [7:0] bus_wdata, bus_rdata, mem_rdata, nv_prot, nv_opt, arr_data, rnd, v;
  logic [63:0] nv_backkey;
  int err_total, total_checks, cyc, pump_offs, prog_cyc, p0, c0, mem_wrs;
  localparam logic [15:0] FL = 16'h2000;
  localparam logic [15:0] RAM = 16'h0100;
  fcp_flash_ctrl u_dut (.core_clk, .rstn, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_dbg,
    .bus_unsec, .bus_rdata, .mem_rdata, .mem_wr, .mem_rd, .nv_prot, .nv_opt, .nv_backkey,
    .stop_req, .vec_fetch, .vec_addr, .arr_blank, .pump_en, .arr_prog, .arr_erase_page,
    .arr_erase_mass, .arr_blank_chk, .arr_addr, .arr_data, .secure);
  fcp_array_model u_arr (.core_clk, .bus_addr, .bus_rd, .arr_prog, .arr_erase_mass,
    .mem_rdata, .arr_blank);
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // ======
  // Helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Lowest protected page FE00: table sits at FDC0
  function automatic logic [15:0] vexp(input logic [15:0] a);
    return (a >= FCP_VEC_LO && a <= FCP_VEC_HI) ? {10'h3F7, a[5:0]} : a;
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chr(input string n, input int lo, input int hi, input int g);
    total_checks++;
    if (g < lo || g > hi)
    begin
      err_total++;
      $display("FAIL %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  // Two cycles per access keeps key writes off adjacent cycles
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [15:0] a);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1;
    v = bus_rdata;
    @(posedge core_clk);
  endtask
  task automatic st(input int b, input logic e);
    rd(FCP_STAT_ADDR);
    chk("status bit", {15'h0, e}, {15'h0, v[b]});
  endtask
  task automatic errc(input logic [15:0] a1, input logic [7:0] d1, input logic [15:0] a2,
    input logic [7:0] d2);
    wr(FL, rnd);
    if (a1 != 16'h0000)
      wr(a1, d1);
    if (a2 != 16'h0000)
      wr(a2, d2);
    st(FCP_ST_ACCERR, 1'b1);
    wr(FCP_STAT_ADDR, 8'h10);
    st(FCP_ST_ACCERR, 1'b0);
  endtask
  task automatic go(input logic [7:0] c, input logic [15:0] a);
    rnd = lfsr(rnd);
    wr(a, rnd);
    wr(FCP_CMD_ADDR, c);
    wr(FCP_STAT_ADDR, 8'h80);
  endtask
  task automatic wcb();
    int n;
    n = 0;
    v = 8'h00;
    while (v[FCP_ST_CBEF] !== 1'b1 && n < 50)
    begin
      rd(FCP_STAT_ADDR);
      n++;
    end
    chk("cbef wait", 16'h0001, {15'h0, v[FCP_ST_CBEF]});
  endtask
  task automatic wid();
    int n;
    n = 0;
    while ((arr_prog || arr_blank_chk || pump_en) && n < 500)
    begin
      @(posedge core_clk);
      n++;
    end
    chr("idle wait", 0, 499, n);
    repeat (2) @(posedge core_clk);
  endtask
  task automatic rst();
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    wr(FCP_DIV_ADDR, 8'h02);
  endtask
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    pump_prev <= pump_en;
    if (pump_prev && !pump_en)
      pump_offs <= pump_offs + 1;
    if (arr_prog)
      prog_cyc <= prog_cyc + 1;
    if (mem_wr)
      mem_wrs <= mem_wrs + 1;
    if (cyc == 30000)
    begin
      err_total++;
      $display("FAIL timeout expected finish seen hang");
      test_done();
    end
  end
  // ======
  // Main sequence
  initial
  begin
    rstn = 1'b0;
    {bus_wr, bus_rd, bus_dbg, bus_unsec, stop_req, vec_fetch} = 6'h00;
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    nv_prot = 8'h00;
    nv_opt = 8'h80;
    rnd = 8'h06;
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      nv_backkey = {nv_backkey[55:0], rnd};
    end
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("secure", 16'h0001, {15'h0, secure});
    rd(FCP_OPT_ADDR);
    chk("option", 16'h0080, {8'h0, v});
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      bus_addr <= (i == 0) ? 16'hFFFE : (16'hFFC0 | {10'h0, rnd[5:0]});
      vec_fetch <= 1'b1;
      @(posedge core_clk);
      vec_fetch <= 1'b0;
      #1;
      chk("vector", vexp(bus_addr), vec_addr);
      @(posedge core_clk);
    end
    errc(16'h0000, 8'h00, 16'h0000, 8'h00);
    wr(FCP_DIV_ADDR, 8'h02);
    wr(FCP_PROT_ADDR, 8'h80);
    rd(FCP_PROT_ADDR);
    chk("protect", 16'h0000, {8'h0, v});
    for (int i = 0; i < 3; i++)
    begin
      go((i == 0) ? FCP_CMD_BYTE : (i == 1) ? FCP_CMD_PAGE : FCP_CMD_MASS, 16'hFE10);
      st(FCP_ST_PVIOL, 1'b1);
      wr(FCP_STAT_ADDR, 8'h20);
    end
    $display("test protect done");
    bus_unsec <= 1'b1;
    rd(FL);
    chk("unsec read", 16'h0000, {8'h0, v});
    bus_unsec <= 1'b0;
    bus_dbg <= 1'b1;
    wr(RAM, 8'h5A);
    chk("blocked write", 16'h0000, 16'(mem_wrs));
    rd(RAM);
    chk("blocked read", 16'h0000, {8'h0, v});
    errc(FCP_CMD_ADDR, FCP_CMD_BYTE, 16'h0000, 8'h00);
    wr(FCP_PROT_ADDR, 8'h80);
    rd(FCP_PROT_ADDR);
    chk("debug protect", 16'h0080, {8'h0, v});
    go(FCP_CMD_BLANK, FL);
    wcb();
    wid();
    chk("blank unlock", 16'h0000, {15'h0, secure});
    bus_dbg <= 1'b0;
    $display("test debug done");
    rst();
    wr(FCP_CFG_ADDR, 8'h20);
    rd(FL);
    chk("key read", 16'h0000, {8'h0, v});
    for (int i = 0; i < 8; i++)
      wr(FCP_KEY_BASE + 16'(i), nv_backkey[63 - 8 * i -: 8]);
    wr(FCP_CFG_ADDR, 8'h00);
    chk("key unlock", 16'h0000, {15'h0, secure});
    rd(FCP_OPT_ADDR);
    chk("option", 16'h0082, {8'h0, v});
    wr(RAM, rnd);
    chk("ram write", 16'h0001, 16'(mem_wrs));
    rd(RAM);
    chk("ram read", 16'h00A5, {8'h0, v});
    $display("test key done");
    errc(FCP_CMD_ADDR, 8'h33, 16'h0000, 8'h00);
    errc(FL, rnd, 16'h0000, 8'h00);
    errc(FCP_CMD_ADDR, FCP_CMD_BYTE, FCP_CMD_ADDR, FCP_CMD_BYTE);
    errc(FCP_CFG_ADDR, 8'h00, 16'h0000, 8'h00);
    errc(FCP_CMD_ADDR, FCP_CMD_BURST, FCP_CFG_ADDR, 8'h00);
    errc(FCP_STAT_ADDR, 8'h00, 16'h0000, 8'h00);
    errc(FCP_CMD_ADDR, FCP_CMD_BYTE, FCP_STAT_ADDR, 8'h00);
    $display("test errors done");
    p0 = pump_offs;
    c0 = prog_cyc;
    go(FCP_CMD_BYTE, FL);
    wcb();
    chk("prog addr", FL, arr_addr);
    chk("prog data", {8'h0, rnd}, {8'h0, arr_data});
    wid();
    chr("byte time", 24, 28, prog_cyc - c0);
    chk("pump offs", 16'h0001, 16'(pump_offs - p0));
    p0 = pump_offs;
    c0 = prog_cyc;
    for (int i = 0; i < 3; i++)
    begin
      go(FCP_CMD_BURST, 16'h203E + 16'(i));
      wcb();
    end
    wid();
    chr("burst time", 60, 69, prog_cyc - c0);
    chk("pump offs", 16'h0002, 16'(pump_offs - p0));
    $display("test program done");
    go(FCP_CMD_BYTE, 16'h2100);
    wcb();
    go(FCP_CMD_BYTE, 16'h2101);
    wr(FL, rnd);
    st(FCP_ST_ACCERR, 1'b1);
    wr(FCP_STAT_ADDR, 8'h10);
    chk("running", 16'h0001, {15'h0, arr_prog});
    stop_req <= 1'b1;
    repeat (2) @(posedge core_clk);
    stop_req <= 1'b0;
    st(FCP_ST_ACCERR, 1'b1);
    wid();
    $display("test stop done");
    test_done();
  end
endmodule

/* File: tb/fcp_monitor.sv */
`timescale 1ns/1ps
module fcp_monitor
  import fcp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic bus_dbg,
  input wire logic bus_unsec,
  input wire logic [7:0] bus_rdata,
  input wire logic mem_wr,
  input wire logic stop_req,
  input wire logic vec_fetch,
  input wire logic [15:0] vec_addr,
  input wire logic arr_blank,
  input wire logic pump_en,
  input wire logic arr_prog,
  input wire logic arr_erase_page,
  input wire logic arr_erase_mass,
  input wire logic arr_blank_chk,
  input wire logic secure
);
  // ======
  // Helpers
  logic [5:0] vec_off;
  logic busy;
  logic blocked;
  assign vec_off = bus_addr[5:0];
  assign busy = arr_prog || arr_erase_page || arr_erase_mass || arr_blank_chk;
  assign blocked = secure && (bus_dbg || bus_unsec);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // ======
  // Properties
  // Four idle cycles leave room for the short gap between burst bytes
  sequence s_quiet;
    !busy [*4];
  endsequence
  sequence s_vec;
    vec_fetch && bus_addr >= FCP_VEC_LO && bus_addr <= FCP_VEC_HI;
  endsequence
  property p_pump_off;
    s_quiet |-> !pump_en;
  endproperty
  property p_pump_prog;
    arr_prog |-> pump_en;
  endproperty
  property p_stop_abort;
    stop_req && arr_prog |-> ##[1:3] !arr_prog;
  endproperty
  property p_wr_block;
    mem_wr |-> bus_wr && !blocked;
  endproperty
  property p_rd_block;
    bus_rd && blocked && bus_addr >= FCP_RAM_LO && bus_addr <= FCP_RAM_HI |=> bus_rdata == 8'h00;
  endproperty
  property p_reset_vec;
    vec_fetch && bus_addr >= 16'hFFFE |=> vec_addr == $past(bus_addr);
  endproperty
  property p_vec_off;
    s_vec |=> vec_addr[5:0] == $past(vec_off);
  endproperty
  property p_blank_open;
    $fell(arr_blank_chk) && arr_blank |-> ##[0:2] !secure;
  endproperty
  a_pump_off: assert property (p_pump_off)
    else $error("pump left on while idle");
  a_pump_prog: assert property (p_pump_prog)
    else $error("programming without pump");
  a_stop_abort: assert property (p_stop_abort)
    else $error("stop did not abort program");
  a_wr_block: assert property (p_wr_block)
    else $error("blocked write reached memory");
  a_rd_block: assert property (p_rd_block)
    else $error("blocked read returned data");
  a_reset_vec: assert property (p_reset_vec)
    else $error("reset vector was moved");
  a_vec_off: assert property (p_vec_off)
    else $error("vector offset changed");
  a_blank_open: assert property (p_blank_open)
    else $error("blank array left device secured");
endmodule
bind fcp_flash_ctrl fcp_monitor u_mon (.core_clk, .rstn, .bus_addr, .bus_wr, .bus_rd, .bus_dbg,
  .bus_unsec, .bus_rdata, .mem_wr, .stop_req, .vec_fetch, .vec_addr, .arr_blank, .pump_en,
  .arr_prog, .arr_erase_page, .arr_erase_mass, .arr_blank_chk, .secure);
